/* fcs_defs.svh */
// Constants for the nonvolatile memory clock divider and command status block.
// Assumes inclusion by bare name; holds definitions only.
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH

// Register byte addresses on the 32-bit bus.
`define FCS_OFF_DIVIDER 5'h00
`define FCS_OFF_STATUS 5'h04
`define FCS_OFF_IRQ_STATUS 5'h08
`define FCS_OFF_IRQ_MASK 5'h0C
`define FCS_OFF_COMMAND 5'h10

// Divider register fields.
`define FCS_DIV_LOADED_BIT 7
`define FCS_DIV_PRESCALE_BIT 6
`define FCS_DIV_RATIO_MSB 5

// Status register fields.
`define FCS_STAT_CBE_BIT 7
`define FCS_STAT_CC_BIT 6
`define FCS_STAT_PV_BIT 5

// Interrupt status bits: command complete and protection violation.
`define FCS_IRQ_CC_BIT 0
`define FCS_IRQ_PV_BIT 1

// Command register fields.
`define FCS_CMD_PROT_BIT 8
`define FCS_CMD_BURST_BIT 9

// Divider reset value and pulse count loaded at the start of each run.
`define FCS_DIVIDER_RST 8'h00
`define FCS_PULSES_RST 4'h4

// Prescaler factor and its counter terminal value.
`define FCS_PRESCALE_FACTOR 8
`define FCS_PRESCALE_LAST 3'h7

`endif

/* fcs_pkg.sv */
// Types shared by the clock divider and command sequencer.
// Assumes fcs_defs.svh is available in the same folder.
package fcs_pkg;
	typedef enum logic [1:0] {
		FCS_IDLE,
		FCS_RUN
	} fcs_state_t;
	typedef logic [7:0] fcs_byte_t;
endpackage

/* fcs_clock_divider.sv */
// Programming clock divider: prescale by eight, then divide by ratio + 1.
// Assumes a single bus clock; the tick is a one-cycle strobe of that clock, held high every cycle at ratio 0 without prescale.
`timescale 1ns/1ns
`include "fcs_defs.svh"
module fcs_clock_divider (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic enable_i,
	input wire logic prescale_by_eight_i,
	input wire logic [5:0] ratio_i,
	output logic programming_clock_o,
	output logic tick_o
);
	import fcs_pkg::*;
	logic [2:0] pre_reg, pre_next;
	logic [5:0] cnt_reg, cnt_next;
	logic tick_reg, tick_next;
	logic pre_step;

	// Counters only move once the divider has been loaded.
	always_comb begin
		pre_step = ~prescale_by_eight_i | (pre_reg == `FCS_PRESCALE_LAST);
		pre_next = enable_i ? pre_reg + 3'h1 : 3'h0;
		cnt_next = cnt_reg;
		tick_next = 1'b0;
		if (!enable_i) begin
			cnt_next = 6'h00;
		end else if (pre_step) begin
			if (cnt_reg >= ratio_i) begin
				cnt_next = 6'h00;
				tick_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 6'h01;
			end
		end
	end

	// Registered state; tick is one bus cycle per programming clock period.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_reg <= 3'h0;
			cnt_reg <= 6'h00;
			tick_reg <= 1'b0;
		end else begin
			pre_reg <= pre_next;
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick_o = tick_reg;
	// Square-ish view of the clock for observation only.
	assign programming_clock_o = enable_i & (cnt_reg <= (ratio_i >> 1));
endmodule

/* fcs_top.sv */
// Nonvolatile memory clock divider and command status front end.
// Assumes a classic Wishbone master on the bus clock.
// Behaviour
// - Divider bit 7 is read-only loaded flag; reset clears, first write sets.
// - Divider bits 6:0 readable always, written only once after reset.
// - Erase or program refused while loaded flag is 0.
// - Bit 6 set feeds divider with bus clock divided by eight.
// - Divider divides its input by ratio field plus one.
// - Each timing pulse is one programming clock period.
// - Buffer-empty clears on write of one only when a burst is queued behind a run; sets again when burst enters array.
// - Only burst program commands may be queued in the buffer.
// - Complete flag sets when buffer empty and idle; clears on launch.
// - Protected target: command ignored, violation flag set, write one clears.
`timescale 1ns/1ns
`include "fcs_defs.svh"
module fcs_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	output logic irq_o,
	output logic programming_active_o
);
	import fcs_pkg::*;

	fcs_state_t state_reg, state_next;
	fcs_pkg::fcs_byte_t divider_reg, divider_next;
	logic cbe_reg, cbe_next;
	logic pv_reg, pv_next;
	logic [1:0] irq_stat_reg, irq_stat_next;
	logic [1:0] irq_mask_reg, irq_mask_next;
	logic [7:0] cmd_reg, cmd_next;
	logic [3:0] pulses_reg, pulses_next;
	logic buf_full_reg, buf_full_next;
	logic buf_prot_reg, buf_prot_next;
	logic [31:0] dat_reg, dat_next;
	logic ack_reg, ack_next;
	logic err_reg, err_next;
	logic irq_reg, irq_next;
	logic active_reg, active_next;
	logic req, wr, rd, hit, cc;
	logic launch, launch_prot, burst;
	logic tick;
	logic cc_rise, cc_prev_reg;
	logic [9:0] gap_reg, gap_next, period_exp;
	logic gap_valid_reg, gap_valid_next;

	// Byte lane zero must be enabled for a write to touch a register.
	function automatic logic lane0(input logic [3:0] sel);
		return sel[0];
	endfunction

	// Known register decode, reused by read and write paths.
	function automatic logic known(input logic [4:0] adr);
		return adr == 5'(`FCS_OFF_DIVIDER) || adr == 5'(`FCS_OFF_STATUS) ||
			adr == 5'(`FCS_OFF_IRQ_STATUS) ||
			adr == 5'(`FCS_OFF_IRQ_MASK) || adr == `FCS_OFF_COMMAND;
	endfunction

	assign req = wb_cyc_i & wb_stb_i & ~ack_reg & ~err_reg;
	assign hit = known(wb_adr_i);
	assign wr = req & hit & wb_we_i & lane0(wb_sel_i);
	assign rd = req & hit & ~wb_we_i;
	// Complete when no command runs and nothing waits in the buffer.
	assign cc = (state_reg == FCS_IDLE) & ~buf_full_reg;

	fcs_clock_divider u_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.enable_i(divider_reg[`FCS_DIV_LOADED_BIT]),
		.prescale_by_eight_i(divider_reg[`FCS_DIV_PRESCALE_BIT]),
		.ratio_i(divider_reg[`FCS_DIV_RATIO_MSB:0]),
		.programming_clock_o(),
		.tick_o(tick)
	);

	// Divider register: the whole byte locks on the first write.
	always_comb begin
		divider_next = divider_reg;
		if (wr && wb_adr_i == 5'(`FCS_OFF_DIVIDER) &&
			!divider_reg[`FCS_DIV_LOADED_BIT]) begin
			divider_next = {1'b1, wb_dat_i[6:0]};
		end
	end

	// Launch happens on a write of one to the buffer-empty bit.
	always_comb begin
		launch = wr && wb_adr_i == 5'(`FCS_OFF_STATUS) &&
			wb_dat_i[`FCS_STAT_CBE_BIT] && cbe_reg;
		launch_prot = cmd_reg[0];
		burst = cmd_reg[1];
	end

	// Command latch: bit 8 marks a protected target, bit 9 a burst.
	always_comb begin
		cmd_next = cmd_reg;
		if (wr && wb_adr_i == `FCS_OFF_COMMAND) begin
			cmd_next = {6'h00, wb_dat_i[`FCS_CMD_BURST_BIT],
				wb_dat_i[`FCS_CMD_PROT_BIT]};
		end
	end

	// Sequencer: runs a fixed count of programming clock pulses.
	always_comb begin
		state_next = state_reg;
		pulses_next = pulses_reg;
		cbe_next = cbe_reg;
		pv_next = pv_reg;
		buf_full_next = buf_full_reg;
		buf_prot_next = buf_prot_reg;
		if (wr && wb_adr_i == 5'(`FCS_OFF_STATUS) &&
			wb_dat_i[`FCS_STAT_PV_BIT]) begin
			pv_next = 1'b0;
		end
		if (launch) begin
			cbe_next = 1'b0;
			if (launch_prot) begin
				pv_next = 1'b1;
				cbe_next = 1'b1;
			end else if (!divider_reg[`FCS_DIV_LOADED_BIT]) begin
				cbe_next = 1'b1;
			end else if (state_reg == FCS_IDLE) begin
				state_next = FCS_RUN;
				pulses_next = `FCS_PULSES_RST;
				cbe_next = 1'b1;
			end else if (burst) begin
				buf_full_next = 1'b1;
				buf_prot_next = launch_prot;
			end else begin
				cbe_next = 1'b1;
			end
		end
		unique case (state_reg)
			FCS_IDLE: begin
				// A burst buffered on the final pulse edge starts here, so
				// the buffer can never be stranded behind an idle sequencer.
				if (buf_full_reg) begin
					state_next = FCS_RUN;
					pulses_next = `FCS_PULSES_RST;
					buf_full_next = 1'b0;
					cbe_next = 1'b1;
				end
			end
			FCS_RUN: begin
				if (tick) begin
					pulses_next = pulses_reg - 4'h1;
					if (pulses_reg == 4'h1) begin
						if (buf_full_reg) begin
							buf_full_next = 1'b0;
							cbe_next = 1'b1;
							pulses_next = `FCS_PULSES_RST;
						end else begin
							state_next = FCS_IDLE;
						end
					end
				end
			end
		endcase
	end

	// Sticky interrupt bits; a hardware set wins over a clear.
	always_comb begin
		cc_rise = cc & ~cc_prev_reg;
		irq_stat_next = irq_stat_reg;
		irq_mask_next = irq_mask_reg;
		if (wr && wb_adr_i == 5'(`FCS_OFF_IRQ_STATUS)) begin
			irq_stat_next = irq_stat_reg & ~wb_dat_i[1:0];
		end
		if (wr && wb_adr_i == 5'(`FCS_OFF_IRQ_MASK)) begin
			irq_mask_next = wb_dat_i[1:0];
		end
		if (cc_rise) begin
			irq_stat_next[`FCS_IRQ_CC_BIT] = 1'b1;
		end
		if (pv_next && !pv_reg) begin
			irq_stat_next[`FCS_IRQ_PV_BIT] = 1'b1;
		end
		irq_next = |(irq_stat_next & irq_mask_next);
		active_next = (state_next == FCS_RUN);
	end

	// Bus answer: one wait cycle, then ack or err for one cycle.
	always_comb begin
		ack_next = req & hit;
		err_next = req & ~hit;
		dat_next = 32'h0000_0000;
		if (rd) begin
			unique case (wb_adr_i)
				5'(`FCS_OFF_DIVIDER): dat_next[7:0] = divider_reg;
				5'(`FCS_OFF_STATUS): dat_next[7:0] = {cbe_reg, cc, pv_reg,
					5'h00};
				5'(`FCS_OFF_IRQ_STATUS): dat_next[1:0] = irq_stat_reg;
				5'(`FCS_OFF_IRQ_MASK): dat_next[1:0] = irq_mask_reg;
				default: dat_next[9:8] = cmd_reg[1:0];
			endcase
		end
	end

	// Cycles between divider ticks and the period the fields ask for.
	// Kept apart from the divider so the period check has its own sum.
	always_comb begin
		gap_next = gap_reg + 10'h001;
		gap_valid_next = gap_valid_reg;
		period_exp = {3'h0, 7'(divider_reg[5:0]) + 7'h01};
		if (divider_reg[`FCS_DIV_PRESCALE_BIT]) begin
			period_exp = {period_exp[6:0], 3'h0};
		end
		if (!divider_reg[`FCS_DIV_LOADED_BIT]) begin
			gap_next = 10'h000;
			gap_valid_next = 1'b0;
		end else if (tick) begin
			gap_next = 10'h001;
			gap_valid_next = 1'b1;
		end
	end

	// All state registers.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= FCS_IDLE;
			divider_reg <= `FCS_DIVIDER_RST;
			cbe_reg <= 1'b1;
			pv_reg <= 1'b0;
			irq_stat_reg <= 2'h0;
			irq_mask_reg <= 2'h0;
			cmd_reg <= 8'h00;
			pulses_reg <= 4'h0;
			buf_full_reg <= 1'b0;
			buf_prot_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
			irq_reg <= 1'b0;
			active_reg <= 1'b0;
			cc_prev_reg <= 1'b1;
			gap_reg <= 10'h000;
			gap_valid_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			divider_reg <= divider_next;
			cbe_reg <= cbe_next;
			pv_reg <= pv_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			cmd_reg <= cmd_next;
			pulses_reg <= pulses_next;
			buf_full_reg <= buf_full_next;
			buf_prot_reg <= buf_prot_next;
			dat_reg <= dat_next;
			ack_reg <= ack_next;
			err_reg <= err_next;
			irq_reg <= irq_next;
			active_reg <= active_next;
			cc_prev_reg <= cc;
			gap_reg <= gap_next;
			gap_valid_reg <= gap_valid_next;
		end
	end

	assign wb_dat_o = dat_reg;
	assign wb_ack_o = ack_reg;
	assign wb_err_o = err_reg;
	assign irq_o = irq_reg;
	assign programming_active_o = active_reg;

	a_div_lock: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(divider_reg[7]) |-> divider_reg == $past(divider_reg))
		else $error("divider changed after lock");
	a_loaded_set: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && wb_adr_i == 5'h00 |=> divider_reg[7])
		else $error("loaded flag not set by write");
	a_no_run_unl: assert property (@(posedge clk_i) disable iff (rst_i)
		!divider_reg[7] |-> state_reg == FCS_IDLE)
		else $error("operation ran without divider");
	a_pv_set: assert property (@(posedge clk_i) disable iff (rst_i)
		launch && cmd_reg[0] |=> pv_reg && !$rose(buf_full_reg) &&
		!(state_reg == FCS_RUN && $past(state_reg) == FCS_IDLE))
		else $error("protected command not refused");
	a_cbe_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		launch && state_reg == FCS_RUN && burst && !cmd_reg[0] |=> !cbe_reg)
		else $error("buffer flag not cleared");
	a_cc_launch: assert property (@(posedge clk_i) disable iff (rst_i)
		launch && !cmd_reg[0] && divider_reg[7] &&
		(state_reg == FCS_IDLE || burst) |=> !cc)
		else $error("complete flag stayed set");
	a_no_queue: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(buf_full_reg) |-> $past(burst))
		else $error("non-burst command queued");
	a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		req && hit |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack timing wrong");
	a_pulse_once: assert property (@(posedge clk_i) disable iff (rst_i)
		tick && period_exp != 10'h001 |=> !tick)
		else $error("pulse longer than one cycle");
	a_tick_period: assert property (@(posedge clk_i) disable iff (rst_i)
		tick && gap_valid_reg |-> gap_reg == period_exp)
		else $error("programming clock period wrong");
	a_pv_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && wb_adr_i == 5'h04 && wb_dat_i[5] && !launch |=> !pv_reg)
		else $error("violation flag not cleared");
	a_queue_drain: assert property (@(posedge clk_i) disable iff (rst_i)
		state_reg == FCS_RUN && tick && pulses_reg == 4'h1 && buf_full_reg
		|=> cbe_reg && state_reg == FCS_RUN && !buf_full_reg)
		else $error("buffered burst not started");
	c_launch: cover property (@(posedge clk_i) launch && !cmd_reg[0]);
	c_burst: cover property (@(posedge clk_i) $rose(buf_full_reg));
	c_viol: cover property (@(posedge clk_i) $rose(pv_reg));
	c_irq: cover property (@(posedge clk_i) $rose(irq_o));
endmodule

/* tb.sv */
// Self-checking bench for the clock divider and command status front end.
// Assumes fcs_top answers each Wishbone request within a few bus cycles.
`timescale 1ns/1ns
`include "fcs_defs.svh"
module tb;
	import fcs_pkg::*;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
	logic [4:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic irq_o, programming_active_o, er;
	int err_total, n_compared, cycles, n;
	fcs_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .irq_o(irq_o),
		.programming_active_o(programming_active_o));
	// The clock runs at 250 MHz.
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	task automatic finish_test();
		$display("Compared %0d, errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// A hung handshake must not stall the run forever.
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			finish_test();
		end
	end
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One classic cycle: request held until ack or err is sampled high.
	// Only the bench timeout ends a wait that never gets its answer.
	task automatic bus(input logic we, input logic [4:0] a,
		input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hF;
		wb_dat_i <= d;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
			@(posedge clk_i);
		end
		rd = wb_dat_o;
		er = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rdchk(string what, logic [4:0] a, logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(what, exp, rd);
	endtask
	task automatic launch(logic [31:0] cmd);
		bus(1'b1, `FCS_OFF_COMMAND, cmd);
		bus(1'b1, `FCS_OFF_STATUS, 32'h80);
	endtask
	task automatic wait_idle();
		n = 0;
		while (programming_active_o === 1'b1 && n < 5000) begin
			@(posedge clk_i);
			n++;
		end
	endtask
	task automatic t_reset();
		rdchk("divider", `FCS_OFF_DIVIDER, 32'h00);
		rdchk("status", `FCS_OFF_STATUS, 32'hC0);
	endtask
	// A launch before the divider is loaded does nothing.
	task automatic t_locked();
		launch(32'h0);
		check("active", 1'b0, programming_active_o);
		rdchk("status", `FCS_OFF_STATUS, 32'hC0);
		bus(1'b0, 5'h14, 32'h0);
		check("err", 1'b1, er);
	endtask
	// Bit 7 is written as 0 yet reads 1; the second write is dropped.
	task automatic t_divider();
		// Slowest setting: at this bus clock no value reaches the window.
		bus(1'b1, `FCS_OFF_DIVIDER, 32'h7F);
		rdchk("divider", `FCS_OFF_DIVIDER, 32'hFF);
		bus(1'b1, `FCS_OFF_DIVIDER, 32'h00);
		rdchk("divider", `FCS_OFF_DIVIDER, 32'hFF);
	endtask
	// Four pulses of 8 * 64 bus cycles; the first may land anywhere in
	// one period after the launch, so the run is 3 to 4 periods long.
	task automatic t_run();
		launch(32'h0);
		check("active", 1'b1, programming_active_o);
		wait_idle();
		check("run length ok", 1'b1, n >= 1536 && n <= 2047);
		rdchk("irq status", `FCS_OFF_IRQ_STATUS, 32'h1);
		check("irq masked", 1'b0, irq_o);
		bus(1'b1, `FCS_OFF_IRQ_MASK, 32'h1);
		check("irq", 1'b1, irq_o);
		bus(1'b1, `FCS_OFF_IRQ_STATUS, 32'h1);
		check("irq cleared", 1'b0, irq_o);
		bus(1'b1, `FCS_OFF_IRQ_MASK, 32'h0);
	endtask
	task automatic t_viol();
		launch(32'h100);
		check("active", 1'b0, programming_active_o);
		rdchk("status", `FCS_OFF_STATUS, 32'hE0);
		rdchk("irq status", `FCS_OFF_IRQ_STATUS, 32'h2);
		bus(1'b1, `FCS_OFF_STATUS, 32'h20);
		rdchk("status", `FCS_OFF_STATUS, 32'hC0);
		bus(1'b1, `FCS_OFF_IRQ_STATUS, 32'h3);
	endtask
	// Plain launch while busy is dropped; a burst fills the buffer.
	task automatic t_burst();
		launch(32'h0);
		rdchk("status", `FCS_OFF_STATUS, 32'h80);
		launch(32'h0);
		rdchk("status", `FCS_OFF_STATUS, 32'h80);
		launch(32'h200);
		rdchk("status", `FCS_OFF_STATUS, 32'h00);
		wait_idle();
		check("burst ran", 1'b1, n >= 2048 && n <= 4096);
		rdchk("status", `FCS_OFF_STATUS, 32'hC0);
	endtask
	// A reset in mid-run re-arms the write-once divider.
	task automatic t_rereset();
		launch(32'h0);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check("active", 1'b0, programming_active_o);
		rdchk("divider", `FCS_OFF_DIVIDER, 32'h00);
		bus(1'b1, `FCS_OFF_DIVIDER, 32'h02);
		rdchk("divider", `FCS_OFF_DIVIDER, 32'h82);
		// Prescale off, ratio 2: four pulses of three bus cycles each.
		launch(32'h0);
		check("active", 1'b1, programming_active_o);
		wait_idle();
		check("short run ok", 1'b1, n >= 9 && n <= 11);
	endtask
	initial begin
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 5'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_locked();
		t_divider();
		t_run();
		t_viol();
		t_burst();
		t_rereset();
		finish_test();
	end
endmodule
